// *** design/oid_decoder.v ***
// output image decoder: splits the cyclic output image into control bits and setpoints
// assumes image bytes arrive in bus order with a last flag on the final byte of each cycle
`timescale 1ns/1ns
`include "oid_regs.vh"
module oid_decoder #(
  parameter AW = 16,
  parameter FIFO_DEPTH = 16
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [7:0] o_rdata,
  input wire i_byte_valid,
  input wire [7:0] i_byte_data,
  input wire i_byte_last,
  output wire o_byte_ready,
  output reg o_idx_latch_en,
  output reg o_rise_latch_en,
  output reg o_preset_strobe,
  output reg o_fall_latch_en,
  output reg [31:0] o_preset_value,
  output reg o_motor_enable,
  output reg o_fault_reset,
  output reg o_torque_reduce,
  output reg o_dig_out1,
  output reg [31:0] o_pos_target,
  output reg [15:0] o_vel_setpoint,
  output reg o_frame_done
);
  // ************************************************
  // states and functions
  // ************************************************
  localparam ST_START = 2'b01;
  localparam ST_RUN = 2'b10;

  function [3:0] set_len;
    input [2:0] s;
    begin
      case (s)
        `OID_SET_ENC_CMP: set_len = `OID_LEN_ENC_CMP;
        `OID_SET_ENC_FULL: set_len = `OID_LEN_ENC_FULL;
        `OID_SET_STEPPER: set_len = `OID_LEN_STEPPER;
        `OID_SET_POSITION: set_len = `OID_LEN_POSITION;
        `OID_SET_VELOCITY: set_len = `OID_LEN_VELOCITY;
        `OID_SET_POS_CMP: set_len = `OID_LEN_POS_CMP;
        `OID_SET_POS_FULL: set_len = `OID_LEN_POS_FULL;
        default: set_len = `OID_LEN_POS_2;
      endcase
    end
  endfunction

  // first assigned set at or above 'from', or none
  function [3:0] next_set;
    input [7:0] m;
    input [3:0] from;
    integer k;
    begin
      next_set = `OID_SET_NONE;
      for (k = 7; k >= 0; k = k - 1) begin
        if (m[k] && (k >= from)) begin
          next_set = k[3:0];
        end
      end
    end
  endfunction

  function excl_hit;
    input [7:0] m;
    begin
      excl_hit = (m[3] && ((m & `OID_EXCL_3) != 8'h00))
        || (m[4] && ((m & `OID_EXCL_4) != 8'h00))
        || (m[5] && ((m & `OID_EXCL_5) != 8'h00))
        || (m[6] && ((m & `OID_EXCL_6) != 8'h00))
        || (m[7] && ((m & `OID_EXCL_7) != 8'h00));
    end
  endfunction

  // ************************************************
  // registers
  // ************************************************
  reg [7:0] assign_q;
  reg hold_q;
  reg [2:0] status_q;
  reg [7:0] frames_q;
  reg [1:0] st_q;
  reg [7:0] act_q;
  reg [3:0] setp_q;
  reg [3:0] bidx_q;
  reg [47:0] acc_q;
  reg [7:0] rd_val;
  reg [2:0] st_set;
  reg [2:0] st_clr;
  reg [7:0] cur_mask;
  reg [3:0] cur_set;
  reg [3:0] cur_idx;
  reg [47:0] asm_word;
  reg set_end;
  reg [3:0] nxt_set;
  wire f_valid;
  wire [8:0] f_data;
  wire take;

  // ************************************************
  // byte fifo
  // ************************************************
  oid_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_byte_valid),
    .i_in_data({i_byte_last, i_byte_data}),
    .o_in_ready(o_byte_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(~hold_q)
  );

  assign take = f_valid & ~hold_q;

  // ************************************************
  // byte assembly
  // ************************************************
  always @* begin
    cur_mask = (st_q == ST_START) ? assign_q : act_q;
    cur_set = (st_q == ST_START) ? next_set(assign_q, 4'h0) : setp_q;
    cur_idx = (st_q == ST_START) ? 4'h0 : bidx_q;
    asm_word = acc_q;
    if (cur_idx < 4'h6) begin
      asm_word[cur_idx*8 +: 8] = f_data[7:0];
    end
    set_end = (cur_set != `OID_SET_NONE) && (cur_idx == set_len(cur_set[2:0]) - 4'h1);
    nxt_set = next_set(cur_mask, cur_set + 4'h1);
  end

  // ************************************************
  // status events and software clears
  // ************************************************
  always @* begin
    st_set = 3'b000;
    st_clr = 3'b000;
    if (i_write && (i_addr == `OID_ASSIGN_ADDR) && excl_hit(i_wdata)) begin
      st_set[`OID_ST_REFUSED] = 1'b1;
    end
    if (take && f_data[8] && !set_end && (cur_set != `OID_SET_NONE)) begin
      st_set[`OID_ST_SHORT] = 1'b1;
    end
    if (take && f_data[8] && set_end && (nxt_set != `OID_SET_NONE)) begin
      st_set[`OID_ST_SHORT] = 1'b1;
    end
    if (take && (cur_set == `OID_SET_NONE)) begin
      st_set[`OID_ST_LONG] = 1'b1;
    end
    if (i_write && (i_addr == `OID_STATUS_ADDR)) begin
      st_clr = i_wdata[2:0];
    end
  end

  // ************************************************
  // register file
  // ************************************************
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      assign_q <= `OID_ASSIGN_RESET;
      hold_q <= 1'b0;
      status_q <= 3'b000;
    end else begin
      if (i_write && (i_addr == `OID_ASSIGN_ADDR) && !excl_hit(i_wdata)) begin
        assign_q <= i_wdata;
      end
      if (i_write && (i_addr == `OID_CTRL_ADDR)) begin
        hold_q <= i_wdata[`OID_CTRL_HOLD];
      end
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  always @* begin
    case (i_addr)
      `OID_POSITION_SET_PARAMS: rd_val = `OID_TABLE_RESET;
      `OID_VELOCITY_SET_PARAMS: rd_val = `OID_TABLE_RESET;
      `OID_COMPACT_POSITIONING_PARAMS: rd_val = `OID_TABLE_RESET;
      `OID_FULL_POSITIONING_PARAMS: rd_val = `OID_TABLE_RESET;
      `OID_SECOND_POSITIONING_PARAMS: rd_val = `OID_TABLE_RESET;
      `OID_COMPACT_ENCODER_MAP: rd_val = `OID_TABLE_RESET;
      `OID_FULL_ENCODER_MAP: rd_val = `OID_TABLE_RESET;
      `OID_STEPPER_CONTROL_MAP: rd_val = `OID_TABLE_RESET;
      `OID_ASSIGN_ADDR: rd_val = assign_q;
      `OID_CTRL_ADDR: rd_val = {7'h00, hold_q};
      `OID_STATUS_ADDR: rd_val = {5'h00, status_q};
      `OID_FRAMES_ADDR: rd_val = frames_q;
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_read ? rd_val : 8'h00;
    end
  end

  // ************************************************
  // frame walker
  // ************************************************
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      st_q <= ST_START;
      act_q <= 8'h00;
      setp_q <= `OID_SET_NONE;
      bidx_q <= 4'h0;
      acc_q <= 48'h0;
      frames_q <= 8'h00;
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= 1'b0;
      if (take) begin
        case (st_q)
          ST_START: begin
            act_q <= assign_q;
          end
          ST_RUN: begin
          end
          default: begin
          end
        endcase
        // sets follow one another byte aligned
        if (set_end) begin
          setp_q <= nxt_set;
          bidx_q <= 4'h0;
          acc_q <= 48'h0;
        end else begin
          setp_q <= cur_set;
          bidx_q <= (cur_set == `OID_SET_NONE) ? cur_idx : cur_idx + 4'h1;
          acc_q <= asm_word;
        end
        if (f_data[8]) begin
          st_q <= ST_START;
          acc_q <= 48'h0;
          bidx_q <= 4'h0;
          frames_q <= frames_q + 8'h01;
          o_frame_done <= 1'b1;
        end else begin
          st_q <= ST_RUN;
        end
      end
    end
  end

  // ************************************************
  // field outputs, updated when a set completes
  // ************************************************
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_idx_latch_en <= 1'b0;
      o_rise_latch_en <= 1'b0;
      o_preset_strobe <= 1'b0;
      o_fall_latch_en <= 1'b0;
      o_preset_value <= 32'h0;
      o_motor_enable <= 1'b0;
      o_fault_reset <= 1'b0;
      o_torque_reduce <= 1'b0;
      o_dig_out1 <= 1'b0;
      o_pos_target <= 32'h0;
      o_vel_setpoint <= 16'h0;
    end else if (take && set_end) begin
      case (cur_set)
        {1'b0, `OID_SET_ENC_CMP}: begin
          o_idx_latch_en <= asm_word[`OID_ENC_IDX_LATCH];
          o_rise_latch_en <= asm_word[`OID_ENC_RISE_LATCH];
          o_preset_strobe <= asm_word[`OID_ENC_PRESET];
          o_fall_latch_en <= asm_word[`OID_ENC_FALL_LATCH];
          o_preset_value <= {16'h0, asm_word[`OID_ENC_VALUE_LSB +: 16]};
        end
        {1'b0, `OID_SET_ENC_FULL}: begin
          o_idx_latch_en <= asm_word[`OID_ENC_IDX_LATCH];
          o_rise_latch_en <= asm_word[`OID_ENC_RISE_LATCH];
          o_preset_strobe <= asm_word[`OID_ENC_PRESET];
          o_fall_latch_en <= asm_word[`OID_ENC_FALL_LATCH];
          o_preset_value <= asm_word[`OID_ENC_VALUE_LSB +: 32];
        end
        {1'b0, `OID_SET_STEPPER}: begin
          o_motor_enable <= asm_word[`OID_STM_ENABLE];
          o_fault_reset <= asm_word[`OID_STM_FAULT_RESET];
          o_torque_reduce <= asm_word[`OID_STM_TORQUE];
          o_dig_out1 <= asm_word[`OID_STM_DIG_OUT1];
        end
        {1'b0, `OID_SET_POSITION}: begin
          o_pos_target <= asm_word[31:0];
        end
        {1'b0, `OID_SET_VELOCITY}: begin
          o_vel_setpoint <= asm_word[15:0];
        end
        default: begin
        end
      endcase
    end
  end
endmodule // oid_decoder

// *** design/oid_fifo.v ***
// byte fifo in front of the output image decoder, registered read data
// assumes DEPTH is a power of two; one extra word sits in the output register
`timescale 1ns/1ns
module oid_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0] count_q;
  reg full_q;
  reg ready_q;
  reg out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire push;
  wire pop;
  wire [AW:0] count_d;

  assign push = i_in_valid & ~full_q;
  assign pop = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | i_out_ready);
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_in_ready = ready_q;
  assign o_out_valid = out_valid_q;
  assign o_out_data = out_data_q;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wptr_q] <= i_in_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      full_q <= 1'b0;
      ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q <= mem[rptr_q];
        out_valid_q <= 1'b1;
      end else if (i_out_ready) begin
        out_valid_q <= 1'b0;
      end
      count_q <= count_d;
      full_q <= (count_d == DEPTH[AW:0]);
      // ready straight from a flop
      ready_q <= (count_d != DEPTH[AW:0]);
    end
  end
endmodule // oid_fifo

// *** design/oid_regs.vh ***
// offsets, field positions, reset values and set layouts of the output image decoder
// assumes a 16-bit register address and byte-wide register data
`ifndef OID_REGS_VH
`define OID_REGS_VH

// ************************************************
// read-only set parameter and map registers
// ************************************************
`define OID_POSITION_SET_PARAMS 16'h1403
`define OID_VELOCITY_SET_PARAMS 16'h1404
`define OID_COMPACT_POSITIONING_PARAMS 16'h1405
`define OID_FULL_POSITIONING_PARAMS 16'h1406
`define OID_SECOND_POSITIONING_PARAMS 16'h1407
`define OID_COMPACT_ENCODER_MAP 16'h1600
`define OID_FULL_ENCODER_MAP 16'h1601
`define OID_STEPPER_CONTROL_MAP 16'h1602
`define OID_TABLE_RESET 8'h06

// ************************************************
// control and status registers
// ************************************************
`define OID_ASSIGN_ADDR 16'h0100
`define OID_CTRL_ADDR 16'h0101
`define OID_STATUS_ADDR 16'h0102
`define OID_FRAMES_ADDR 16'h0103
`define OID_ASSIGN_RESET 8'h05
`define OID_CTRL_HOLD 0
`define OID_ST_REFUSED 0
`define OID_ST_SHORT 1
`define OID_ST_LONG 2

// ************************************************
// mapping set numbers (bit of the assignment register)
// ************************************************
`define OID_SET_ENC_CMP 3'd0
`define OID_SET_ENC_FULL 3'd1
`define OID_SET_STEPPER 3'd2
`define OID_SET_POSITION 3'd3
`define OID_SET_VELOCITY 3'd4
`define OID_SET_POS_CMP 3'd5
`define OID_SET_POS_FULL 3'd6
`define OID_SET_POS_2 3'd7
`define OID_SET_NONE 4'h8

// byte lengths of each set in the image
`define OID_LEN_ENC_CMP 4'h4
`define OID_LEN_ENC_FULL 4'h6
`define OID_LEN_STEPPER 4'h2
`define OID_LEN_POSITION 4'h4
`define OID_LEN_VELOCITY 4'h2
`define OID_LEN_POS_CMP 4'h6
`define OID_LEN_POS_FULL 4'hE
`define OID_LEN_POS_2 4'hE

// sets that must not be assigned with sets 3..7
`define OID_EXCL_3 8'h70
`define OID_EXCL_4 8'h68
`define OID_EXCL_5 8'h58
`define OID_EXCL_6 8'h38
`define OID_EXCL_7 8'h38

// ************************************************
// bit positions inside a set
// ************************************************
`define OID_ENC_IDX_LATCH 0
`define OID_ENC_RISE_LATCH 1
`define OID_ENC_PRESET 2
`define OID_ENC_FALL_LATCH 3
`define OID_ENC_VALUE_LSB 16
`define OID_STM_ENABLE 0
`define OID_STM_FAULT_RESET 1
`define OID_STM_TORQUE 2
`define OID_STM_DIG_OUT1 11

`endif

// *** testbench/oid_img_master.sv ***
// image master model: offers output image bytes with valid and last, holds until taken
// assumes the decoder samples valid, data and last on the rising clock edge
`timescale 1ns/1ns
module oid_img_master (
  input logic i_clk,
  input logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last
);
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
  end
  // ****************
  // byte offer
  // ****************
  // released data line shows the inverse of the last byte
  task automatic idle;
    o_valid <= 1'b0;
    o_data <= ~o_data;
    o_last <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input logic l, input int gap, output bit ok);
    int k;
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge i_clk);
    end
    o_valid <= 1'b1;
    o_data <= d;
    o_last <= l;
    k = 0;
    // ready is registered: its mid-cycle value is the one seen at the next edge
    do begin
      @(negedge i_clk);
      ok = (i_ready === 1'b1);
      @(posedge i_clk);
      k++;
    end while (!ok && k < 300);
  endtask
endmodule // oid_img_master

// *** testbench/oid_properties.sv ***
// checker of the output image decoder: register reads, image pulses, set gating
// assumes it is bound to oid_decoder and the assignment only changes between images
`timescale 1ns/1ns
`include "oid_regs.vh"
module oid_properties #(
  parameter AW = 16,
  parameter FIFO_DEPTH = 16
) (
  input logic i_clk,
  input logic i_resetn,
  input logic [AW-1:0] i_addr,
  input logic [7:0] i_wdata,
  input logic i_write,
  input logic i_read,
  input logic [7:0] o_rdata,
  input logic i_byte_valid,
  input logic i_byte_last,
  input logic o_byte_ready,
  input logic o_idx_latch_en,
  input logic o_rise_latch_en,
  input logic o_preset_strobe,
  input logic o_fall_latch_en,
  input logic [31:0] o_preset_value,
  input logic o_motor_enable,
  input logic o_fault_reset,
  input logic o_torque_reduce,
  input logic o_dig_out1,
  input logic [31:0] o_pos_target,
  input logic [15:0] o_vel_setpoint,
  input logic o_frame_done
);
  // ****************
  // shadow state
  // ****************
  logic [7:0] asg_q;
  logic [7:0] pend_q;
  logic hold_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  function automatic logic legal(input logic [7:0] d);
    legal = ($countones(d[6:3]) <= 1) && !(d[7] && |d[5:3]);
  endfunction
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      asg_q <= `OID_ASSIGN_RESET;
      pend_q <= 8'h00;
      hold_q <= 1'b0;
    end else begin
      if (i_write && i_addr == `OID_ASSIGN_ADDR && legal(i_wdata)) asg_q <= i_wdata;
      if (i_write && i_addr == `OID_CTRL_ADDR) hold_q <= i_wdata[0];
      pend_q <= pend_q + 8'(i_byte_valid && o_byte_ready && i_byte_last) - 8'(o_frame_done);
    end
  end
  // ****************
  // properties
  // ****************
  AST_TABLE_RD: assert property (
    i_read && (i_addr inside {[16'h1403:16'h1407], [16'h1600:16'h1602]})
    |=> o_rdata == `OID_TABLE_RESET) else $error("table register read wrong");
  AST_ASSIGN_RD: assert property (
    i_read && i_addr == `OID_ASSIGN_ADDR |=> o_rdata == asg_q)
    else $error("assignment not as written or not refused");
  AST_DONE_PULSE: assert property (
    o_frame_done |=> !o_frame_done) else $error("frame done longer than one cycle");
  AST_DONE_CAUSE: assert property (
    o_frame_done |-> pend_q != 8'h00) else $error("frame done without a last byte");
  AST_DONE_WITHIN: assert property (
    i_byte_valid && o_byte_ready && i_byte_last && !hold_q |-> ##[2:40] o_frame_done)
    else $error("frame done missing after last byte");
  AST_PRESET_CMP: assert property (
    asg_q[1:0] == 2'b01 && $changed(o_preset_value) |-> o_preset_value[31:16] == 16'h0000)
    else $error("compact preset not zero extended");
  AST_ENC_QUIET: assert property (
    asg_q[1:0] == 2'b00 |-> $stable({o_idx_latch_en, o_rise_latch_en, o_preset_strobe,
    o_fall_latch_en, o_preset_value})) else $error("encoder outputs moved unassigned");
  AST_STM_QUIET: assert property (
    !asg_q[2] |-> $stable({o_motor_enable, o_fault_reset, o_torque_reduce, o_dig_out1}))
    else $error("stepper outputs moved unassigned");
  AST_POS_QUIET: assert property (
    !asg_q[3] |-> $stable(o_pos_target)) else $error("position moved unassigned");
  AST_VEL_QUIET: assert property (
    !asg_q[4] |-> $stable(o_vel_setpoint)) else $error("velocity moved unassigned");
  cover property (o_frame_done);
  cover property (i_write && i_addr == `OID_ASSIGN_ADDR && !legal(i_wdata));
  cover property (i_byte_valid && !o_byte_ready);
endmodule // oid_properties

bind oid_decoder oid_properties #(.AW(AW), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_byte_valid(i_byte_valid),
  .i_byte_last(i_byte_last), .o_byte_ready(o_byte_ready), .o_idx_latch_en(o_idx_latch_en),
  .o_rise_latch_en(o_rise_latch_en), .o_preset_strobe(o_preset_strobe),
  .o_fall_latch_en(o_fall_latch_en), .o_preset_value(o_preset_value),
  .o_motor_enable(o_motor_enable), .o_fault_reset(o_fault_reset),
  .o_torque_reduce(o_torque_reduce), .o_dig_out1(o_dig_out1),
  .o_pos_target(o_pos_target), .o_vel_setpoint(o_vel_setpoint),
  .o_frame_done(o_frame_done));

// *** testbench/testbench.sv ***
// testbench: register, image decode, refusal and buffer tests against a queue model
// assumes oid_decoder, oid_fifo, the image master and the checker are compiled first
`timescale 1ns/1ns
`include "oid_regs.vh"
module testbench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [7:0] o_rdata, bd;
  logic bv, bl, rdy, il, rl, ps, fl, me, fr, tr, d1, fd;
  logic [31:0] pv, pt;
  logic [15:0] vs;
  logic [3:0] e_enc = 4'h0;
  logic [3:0] e_stm = 4'h0;
  logic [31:0] e_pv = 32'h0;
  logic [31:0] e_pt = 32'h0;
  logic [15:0] e_vs = 16'h0;
  int bad_count = 0;
  int n_compared = 0;
  int n_img = 0;
  int lens[8] = '{4, 6, 2, 4, 2, 6, 14, 14};
  logic [15:0] tbl[8] = '{16'h1403, 16'h1404, 16'h1405, 16'h1406, 16'h1407,
                         16'h1600, 16'h1601, 16'h1602};
  logic [7:0] good[9] = '{8'h04, 8'h05, 8'h06, 8'h0A, 8'h11, 8'h24, 8'h45, 8'h86, 8'hC4};
  logic [7:0] bad[9] = '{8'h18, 8'h28, 8'h48, 8'h30, 8'h50, 8'h60, 8'h88, 8'h90, 8'hA0};

  oid_decoder #(.AW(16), .FIFO_DEPTH(16)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_byte_valid(bv),
    .i_byte_data(bd), .i_byte_last(bl), .o_byte_ready(rdy), .o_idx_latch_en(il),
    .o_rise_latch_en(rl), .o_preset_strobe(ps), .o_fall_latch_en(fl), .o_preset_value(pv),
    .o_motor_enable(me), .o_fault_reset(fr), .o_torque_reduce(tr), .o_dig_out1(d1),
    .o_pos_target(pt), .o_vel_setpoint(vs), .o_frame_done(fd));
  oid_img_master u_mst (.i_clk(i_clk), .i_ready(rdy), .o_valid(bv), .o_data(bd), .o_last(bl));

  initial forever #10 i_clk = ~i_clk;

  // ****************
  // shared tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clk);
    i_read <= 1'b0;
    #1 check($sformatf("reg %h", a), 32'(o_rdata), 32'(e));
  endtask
  task automatic frame(input logic [7:0] asg, input int extra, input bit hold);
    logic [7:0] b[$];
    int n, p, k;
    bit ok, sh;
    n = extra;
    n_img++;
    for (k = 0; k < 8; k++) if (asg[k]) n += lens[k];
    wr(`OID_ASSIGN_ADDR, asg);
    if (hold) wr(`OID_CTRL_ADDR, 8'h01);
    for (k = 0; k < n; k++) b.push_back(8'($urandom));
    for (k = 0; k < n; k++) begin
      u_mst.send(b[k], k == n - 1, hold ? 0 : $urandom_range(2), ok);
      if (!ok) begin
        bad_count++;
        stop_test;
      end
    end
    u_mst.idle();
    if (hold) begin
      @(posedge i_clk);
      #1 check("byte ready held", 32'(rdy), 32'h0);
      wr(`OID_CTRL_ADDR, 8'h00);
    end
    k = 0;
    while (fd !== 1'b1 && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (fd !== 1'b1) begin
      bad_count++;
      stop_test;
    end
    p = 0;
    sh = 0;
    for (k = 0; k < 8; k++) begin
      if (asg[k] && !sh && p + lens[k] > n) sh = 1;
      else if (asg[k] && !sh) begin
        if (k < 2) e_enc = b[p][3:0];
        if (k == 0) e_pv = {16'h0000, b[p+3], b[p+2]};
        if (k == 1) e_pv = {b[p+5], b[p+4], b[p+3], b[p+2]};
        if (k == 2) e_stm = {b[p][0], b[p][1], b[p][2], b[p+1][3]};
        if (k == 3) e_pt = {b[p+3], b[p+2], b[p+1], b[p]};
        if (k == 4) e_vs = {b[p+1], b[p]};
        p += lens[k];
      end
    end
    #1 check("encoder bits", 32'({fl, ps, rl, il}), 32'(e_enc));
    check("preset value", pv, e_pv);
    check("stepper bits", 32'({me, fr, tr, d1}), 32'(e_stm));
    check("position target", pt, e_pt);
    check("velocity setpoint", 32'(vs), 32'(e_vs));
    rdchk(`OID_STATUS_ADDR, {5'h00, !sh && n > p, sh, 1'b0});
    wr(`OID_STATUS_ADDR, 8'h07);
    $display("frame %h of %0d bytes done", asg, n);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(61));
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    foreach (tbl[k]) begin
      wr(tbl[k], 8'hFF);
      rdchk(tbl[k], `OID_TABLE_RESET);
    end
    rdchk(`OID_ASSIGN_ADDR, `OID_ASSIGN_RESET);
    rdchk(`OID_CTRL_ADDR, 8'h00);
    rdchk(`OID_FRAMES_ADDR, 8'h00);
    rdchk(16'h0200, 8'h00);
    $display("register test done");
    foreach (good[k]) frame(good[k], 0, 1'b0);
    frame(8'h05, -1, 1'b0);
    $display("decode test done");
    wr(`OID_ASSIGN_ADDR, 8'h01);
    foreach (bad[k]) begin
      wr(`OID_ASSIGN_ADDR, bad[k]);
      rdchk(`OID_ASSIGN_ADDR, 8'h01);
      rdchk(`OID_STATUS_ADDR, 8'h01);
      wr(`OID_STATUS_ADDR, 8'h01);
    end
    $display("refusal test done");
    frame(8'h04, 15, 1'b1);
    $display("buffer test done");
    rdchk(`OID_FRAMES_ADDR, 8'(n_img));
    stop_test;
  end
endmodule // testbench
